// ---- hw/rrc_pkg.sv ----
`default_nettype none
package rrc_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int unsigned RRC_CLK_HZ      = 20_000_000;
	localparam int unsigned RRC_DEBOUNCE_MS = 100;
	localparam int unsigned RRC_WORD_GAP_S  = 10;
	localparam int unsigned RRC_CNT_W       = 28;
	// Debounce rounds down (exact here); gap limit is a plain product, nothing rounds
	localparam int unsigned RRC_DEB_CYC     = RRC_DEBOUNCE_MS * (RRC_CLK_HZ / 1000);
	localparam int unsigned RRC_GAP_CYC     = RRC_WORD_GAP_S * RRC_CLK_HZ;

	// ----------------------------------------------------------------
	// Word codes, bit set = line changed (lines 3..0)
	// ----------------------------------------------------------------
	typedef logic [3:0] rrc_word_t;
	localparam rrc_word_t RRC_W_START   = 4'hF;
	localparam rrc_word_t RRC_W_EXECUTE = 4'hC;
	localparam rrc_word_t RRC_W_AUTO    = 4'h2;
	localparam rrc_word_t RRC_W_REMOTE  = 4'h1;
	localparam rrc_word_t RRC_W_MOD1    = 4'hD;
	localparam rrc_word_t RRC_W_MOD2    = 4'hE;
	localparam rrc_word_t RRC_W_DEMOD1  = 4'h9;
	localparam rrc_word_t RRC_W_DEMOD2  = 4'hA;
	localparam rrc_word_t RRC_W_NONE    = 4'h0;
	localparam rrc_word_t RRC_PRIME_MIN = 4'h1;
	localparam rrc_word_t RRC_PRIME_MAX = 4'h8;
	// Pulled-up lines read high when open
	localparam rrc_word_t RRC_LINES_IDLE = 4'hF;

	// ----------------------------------------------------------------
	// Backup units: 0 mod 1, 1 mod 2, 2 demod 1, 3 demod 2
	// ----------------------------------------------------------------
	localparam int unsigned RRC_NUM_BACKUP = 4;
	typedef logic [1:0] rrc_sel_t;

	typedef struct packed {
		logic      online;
		rrc_word_t prime;
	} rrc_backup_s;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_FUNC,
		ST_SEL,
		ST_EXEC
	} rrc_state_e;

	typedef enum logic [2:0] {
		PK_NONE,
		PK_AUTO,
		PK_REMOTE,
		PK_ONLINE,
		PK_OFFLINE
	} rrc_pend_e;

endpackage
`default_nettype wire

// ---- hw/rrc_decoder.sv ----
// Contract
// - Four pulled-up lines; open reads high
// - Word recognised 100 ms after change
// - Repeated word registers only once
// - Command is three or four words
// - Order: start, function, target, execute
// - Target only for putting backup online
// - Act only after valid words and execute
// - Over 10 s gap clears, await start
// - Start word always restarts the sequence
// - Start, execute, auto, remote word codes
// - Backup selector word codes
// - Target word is prime 1..8 binary
// - Auto accepted only in remote mode
// - Remote from other modes; others need remote
// - Selector+target online; selector+execute offline
`timescale 1ns/100ps
`default_nettype none
module rrc_decoder
	import rrc_pkg::*;
#(
	parameter logic [RRC_CNT_W-1:0] DEB_CYC = RRC_CNT_W'(RRC_DEB_CYC),
	parameter logic [RRC_CNT_W-1:0] GAP_CYC = RRC_CNT_W'(RRC_GAP_CYC)
) (
	input  wire logic                       sys_clk,
	input  wire logic                       resetn,
	input  wire logic                       cmdLineBit3,
	input  wire logic                       cmdLineBit2,
	input  wire logic                       cmdLineBit1,
	input  wire logic                       cmdLineBit0,
	output var  logic                       modeRemote,
	output var  rrc_backup_s [RRC_NUM_BACKUP-1:0] backupState,
	output var  logic                       cmdDone,
	output var  logic                       cmdReject
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	rrc_word_t                       lines;
	rrc_word_t                       prevSample_ff;
	rrc_word_t                       refLevel_ff;
	logic [RRC_CNT_W-1:0]            debCnt_ff;
	logic                            wordStb_ff;
	rrc_word_t                       wordCode_ff;
	rrc_word_t                       lastWord_ff;
	logic                            newWord;
	logic [RRC_CNT_W-1:0]            gapCnt_ff;
	logic                            gapExpired;
	rrc_state_e                      state_ff;
	rrc_state_e                      nxt_state;
	rrc_pend_e                       pend_ff;
	rrc_pend_e                       nxt_pend;
	rrc_pend_e                       applyKind;
	rrc_sel_t                        selIdx_ff;
	rrc_sel_t                        nxt_selIdx;
	rrc_word_t                       target_ff;
	rrc_word_t                       nxt_target;
	logic                            rejectNow;
	logic                            isSel;
	rrc_sel_t                        selCode;
	logic                            modeRemote_ff;
	rrc_backup_s [RRC_NUM_BACKUP-1:0] backup_ff;
	logic                            cmdDone_ff;
	logic                            cmdReject_ff;

	// Lines arrive already synchronous; open line reads as one
	assign lines = {cmdLineBit3, cmdLineBit2, cmdLineBit1, cmdLineBit0};

	// ----------------------------------------------------------------
	// Debounce and word forming
	// ----------------------------------------------------------------
	// Any wobble restarts the settle time, so contact bounce never forms a word
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			prevSample_ff <= RRC_LINES_IDLE;
			debCnt_ff     <= '0;
			refLevel_ff   <= RRC_LINES_IDLE;
			wordStb_ff    <= 1'b0;
			wordCode_ff   <= RRC_W_NONE;
		end else begin
			prevSample_ff <= lines;
			wordStb_ff    <= 1'b0;
			if (lines != prevSample_ff || lines == refLevel_ff) begin
				debCnt_ff <= '0;
			end else if (debCnt_ff == DEB_CYC - 1'b1) begin
				debCnt_ff   <= '0;
				refLevel_ff <= lines;
				wordStb_ff  <= 1'b1;
				wordCode_ff <= lines ^ refLevel_ff;
			end else begin
				debCnt_ff <= debCnt_ff + 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Repeat filter
	// ----------------------------------------------------------------
	// Return-to-zero senders produce the same code twice; the echo is dropped
	assign newWord = wordStb_ff && (wordCode_ff != lastWord_ff);

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			lastWord_ff <= RRC_W_NONE;
		end else if (gapExpired) begin
			lastWord_ff <= RRC_W_NONE;
		end else if (newWord) begin
			lastWord_ff <= wordCode_ff;
		end
	end

	// ----------------------------------------------------------------
	// Inter-word gap timer
	// ----------------------------------------------------------------
	assign gapExpired = (state_ff != ST_IDLE) && !newWord && (gapCnt_ff == GAP_CYC - 1'b1);

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			gapCnt_ff <= '0;
		end else if (newWord || state_ff == ST_IDLE || gapExpired) begin
			gapCnt_ff <= '0;
		end else begin
			gapCnt_ff <= gapCnt_ff + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Word sequencer
	// ----------------------------------------------------------------
	// Selector decode
	always_comb begin
		isSel   = 1'b1;
		selCode = 2'd0;
		case (wordCode_ff)
			RRC_W_MOD1:   selCode = 2'd0;
			RRC_W_MOD2:   selCode = 2'd1;
			RRC_W_DEMOD1: selCode = 2'd2;
			RRC_W_DEMOD2: selCode = 2'd3;
			default:      isSel   = 1'b0;
		endcase
	end

	// Next state; any wrong word drops back to waiting for start
	always_comb begin
		nxt_state  = state_ff;
		nxt_pend   = pend_ff;
		nxt_selIdx = selIdx_ff;
		nxt_target = target_ff;
		applyKind  = PK_NONE;
		rejectNow  = 1'b0;
		if (gapExpired) begin
			nxt_state = ST_IDLE;
			nxt_pend  = PK_NONE;
		end else if (newWord && wordCode_ff == RRC_W_START) begin
			nxt_state = ST_FUNC;
			nxt_pend  = PK_NONE;
		end else if (newWord) begin
			nxt_state = ST_IDLE;
			case (state_ff)
				ST_IDLE: begin
					nxt_state = ST_IDLE;
				end
				ST_FUNC: begin
					if (wordCode_ff == RRC_W_AUTO && modeRemote_ff) begin
						nxt_pend  = PK_AUTO;
						nxt_state = ST_EXEC;
					end else if (wordCode_ff == RRC_W_REMOTE && !modeRemote_ff) begin
						nxt_pend  = PK_REMOTE;
						nxt_state = ST_EXEC;
					end else if (isSel && modeRemote_ff) begin
						nxt_selIdx = selCode;
						nxt_state  = ST_SEL;
					end else begin
						rejectNow = 1'b1;
					end
				end
				ST_SEL: begin
					if (wordCode_ff == RRC_W_EXECUTE) begin
						applyKind = PK_OFFLINE;
					end else if (wordCode_ff >= RRC_PRIME_MIN &&
						wordCode_ff <= RRC_PRIME_MAX) begin
						nxt_target = wordCode_ff;
						nxt_pend   = PK_ONLINE;
						nxt_state  = ST_EXEC;
					end else begin
						rejectNow = 1'b1;
					end
				end
				ST_EXEC: begin
					if (wordCode_ff == RRC_W_EXECUTE) begin
						applyKind = pend_ff;
					end else begin
						rejectNow = 1'b1;
					end
				end
				default: begin
					nxt_state = ST_IDLE;
				end
			endcase
			if (nxt_state == ST_IDLE) begin
				nxt_pend = PK_NONE;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state_ff  <= ST_IDLE;
			pend_ff   <= PK_NONE;
			selIdx_ff <= 2'd0;
			target_ff <= RRC_W_NONE;
		end else begin
			state_ff  <= nxt_state;
			pend_ff   <= nxt_pend;
			selIdx_ff <= nxt_selIdx;
			target_ff <= nxt_target;
		end
	end

	// ----------------------------------------------------------------
	// Operating mode and backup status
	// ----------------------------------------------------------------
	// Powers up in automatic operation
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			modeRemote_ff <= 1'b0;
		end else if (applyKind == PK_REMOTE) begin
			modeRemote_ff <= 1'b1;
		end else if (applyKind == PK_AUTO) begin
			modeRemote_ff <= 1'b0;
		end
	end

	// One backup changes per command; the rest hold
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			backup_ff <= '0;
		end else begin
			for (int i = 0; i < RRC_NUM_BACKUP; i++) begin
				if (selIdx_ff == rrc_sel_t'(i)) begin
					if (applyKind == PK_ONLINE) begin
						backup_ff[i].online <= 1'b1;
						backup_ff[i].prime  <= target_ff;
					end else if (applyKind == PK_OFFLINE) begin
						backup_ff[i].online <= 1'b0;
						backup_ff[i].prime  <= RRC_W_NONE;
					end
				end
			end
		end
	end

	// Result pulses
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			cmdDone_ff   <= 1'b0;
			cmdReject_ff <= 1'b0;
		end else begin
			cmdDone_ff   <= (applyKind != PK_NONE);
			cmdReject_ff <= rejectNow || gapExpired;
		end
	end

	assign modeRemote  = modeRemote_ff;
	assign backupState = backup_ff;
	assign cmdDone     = cmdDone_ff;
	assign cmdReject   = cmdReject_ff;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	// Helper: cycles the lines have held still
	logic [RRC_CNT_W-1:0] stableCnt_ff;
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			stableCnt_ff <= '0;
		end else if (lines != prevSample_ff) begin
			stableCnt_ff <= '0;
		end else if (stableCnt_ff != '1) begin
			stableCnt_ff <= stableCnt_ff + 1'b1;
		end
	end

	a_debounce_settle: assert property (@(posedge sys_clk) disable iff (!resetn)
		wordStb_ff |-> ($past(stableCnt_ff) >= DEB_CYC - 1'b1))
		else $error("word formed before settle time");
	a_word_from_ref: assert property (@(posedge sys_clk) disable iff (!resetn)
		wordStb_ff |-> (wordCode_ff == (refLevel_ff ^ $past(refLevel_ff))))
		else $error("word code not change pattern");
	a_repeat_ignored: assert property (@(posedge sys_clk) disable iff (!resetn)
		(wordStb_ff && !newWord && !gapExpired) |=> $stable(state_ff) && !cmdDone_ff)
		else $error("repeated word acted on");
	a_start_restarts: assert property (@(posedge sys_clk) disable iff (!resetn)
		(newWord && wordCode_ff == RRC_W_START) |=> (state_ff == ST_FUNC))
		else $error("start word did not restart");
	a_gap_timeout: assert property (@(posedge sys_clk) disable iff (!resetn)
		gapExpired |=> (state_ff == ST_IDLE) && cmdReject_ff && (lastWord_ff == RRC_W_NONE))
		else $error("gap timeout not handled");

	// Result pulses land on the same edge as the state change they report
	a_auto_gate: assert property (@(posedge sys_clk) disable iff (!resetn)
		(newWord && state_ff == ST_FUNC && wordCode_ff == RRC_W_AUTO && !modeRemote_ff)
		|=> (state_ff == ST_IDLE) && cmdReject_ff && !cmdDone_ff)
		else $error("auto accepted outside remote");
	a_local_locked: assert property (@(posedge sys_clk) disable iff (!resetn)
		!modeRemote_ff |=> $stable(backup_ff))
		else $error("backup changed outside remote");
	a_exec_required: assert property (@(posedge sys_clk) disable iff (!resetn)
		$changed(modeRemote_ff) |-> $past(newWord) && ($past(wordCode_ff) == RRC_W_EXECUTE))
		else $error("mode changed without execute");
	a_offline_direct: assert property (@(posedge sys_clk) disable iff (!resetn)
		(newWord && state_ff == ST_SEL && wordCode_ff == RRC_W_EXECUTE)
		|=> !backup_ff[selIdx_ff].online && cmdDone_ff)
		else $error("selector then execute not offline");
	a_prime_range: assert property (@(posedge sys_clk) disable iff (!resetn)
		(applyKind == PK_ONLINE) |=> backup_ff[$past(selIdx_ff)].online &&
		(backup_ff[$past(selIdx_ff)].prime >= RRC_PRIME_MIN) &&
		(backup_ff[$past(selIdx_ff)].prime <= RRC_PRIME_MAX))
		else $error("online prime out of range");

	c_enter_remote: cover property (@(posedge sys_clk) disable iff (!resetn)
		$rose(modeRemote_ff));
	c_backup_online: cover property (@(posedge sys_clk) disable iff (!resetn)
		applyKind == PK_ONLINE);
	c_gap_timeout: cover property (@(posedge sys_clk) disable iff (!resetn)
		gapExpired);
	c_repeat_word: cover property (@(posedge sys_clk) disable iff (!resetn)
		wordStb_ff && !newWord);

endmodule
`default_nettype wire

// ---- bench/rrc_line_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// Contact closures on the four pulled-up command lines
// ----------------------------------------------------------------
module rrc_line_model
	import rrc_pkg::*;
#(
	parameter int HOLD  = 40,
	parameter int SPACE = 100
) (
	input  wire logic sys_clk,
	output var  logic cmdLineBit3,
	output var  logic cmdLineBit2,
	output var  logic cmdLineBit1,
	output var  logic cmdLineBit0
);
	rrc_word_t closed = 4'h0;

	// Open contact floats to the pull-up, closed contact grounds the line
	always_comb begin
		{cmdLineBit3, cmdLineBit2, cmdLineBit1, cmdLineBit0} = ~closed;
	end

	// Toggle the named lines; a pulse-return word swings back after the hold,
	// which the decoder must see as a repeat and drop
	task automatic sendWord(input rrc_word_t w, input logic rz);
		@(posedge sys_clk);
		#1 closed = closed ^ w;
		if (rz) begin
			repeat (HOLD) @(posedge sys_clk);
			#1 closed = closed ^ w;
			repeat (SPACE - HOLD) @(posedge sys_clk);
		end else begin
			repeat (SPACE) @(posedge sys_clk);
		end
	endtask
endmodule
`default_nettype wire

// ---- bench/rrc_decoder_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module rrc_decoder_tb_top
	import rrc_pkg::*;
;
	// ----------------------------------------------------------------
	// Signals and the unit under test
	// ----------------------------------------------------------------
	// Short counts keep the run small; the word spacing stays under the gap
	localparam logic [RRC_CNT_W-1:0] DEB = 28'h14;
	localparam logic [RRC_CNT_W-1:0] GAP = 28'h1F4;
	logic sys_clk = 1'b0;
	logic resetn  = 1'b0;
	logic b3, b2, b1, b0;
	logic modeRemote, cmdDone, cmdReject;
	rrc_backup_s [RRC_NUM_BACKUP-1:0] backupState;
	rrc_backup_s [RRC_NUM_BACKUP-1:0] expBk = '0;
	int errors = 0, nCompared = 0, nDone = 0, nRej = 0, cycles = 0, gr;

	rrc_decoder #(.DEB_CYC(DEB), .GAP_CYC(GAP)) i_rrc_decoder (
		.sys_clk     (sys_clk),
		.resetn      (resetn),
		.cmdLineBit3 (b3),
		.cmdLineBit2 (b2),
		.cmdLineBit1 (b1),
		.cmdLineBit0 (b0),
		.modeRemote  (modeRemote),
		.backupState (backupState),
		.cmdDone     (cmdDone),
		.cmdReject   (cmdReject)
	);

	rrc_line_model i_rrc_line_model (
		.sys_clk     (sys_clk),
		.cmdLineBit3 (b3),
		.cmdLineBit2 (b2),
		.cmdLineBit1 (b1),
		.cmdLineBit0 (b0)
	);

	always #25 sys_clk = ~sys_clk;

	// Count pulses per edge so a stuck pulse shows as an excess count
	always @(posedge sys_clk) begin
		cycles++;
		if (cmdDone === 1'b1) nDone++;
		if (cmdReject === 1'b1) nRej++;
		if (cycles == 20000) begin
			errors++;
			conclude();
		end
	end

	// ----------------------------------------------------------------
	// Checking and sequences
	// ----------------------------------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		nCompared++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Send n words, first word in the top nibble, then compare the outcome
	task automatic runSeq(input logic [23:0] w, input int n, input logic rz, input logic eRem,
		input int idx, input logic [4:0] bk, input int eDone, input int eRej);
		int d0, r0;
		d0 = nDone;
		r0 = nRej;
		for (int k = 0; k < n; k++) begin
			i_rrc_line_model.sendWord(w[23-4*k -: 4], rz);
		end
		if (idx >= 0) expBk[idx] = rrc_backup_s'(bk);
		check("modeRemote", modeRemote, eRem);
		check("backupState", backupState, expBk);
		check("cmdDone", nDone - d0, eDone);
		check("cmdReject", nRej - r0, eRej);
	endtask

	task automatic conclude();
		$display("compared %0d mismatches %0d", nCompared, errors);
		if (errors == 0 && nCompared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Ordinary commands: words, count, mode, unit, state, done, reject
	// ----------------------------------------------------------------
	typedef struct {
		logic [23:0] words;
		int          n;
		logic        eRem;
		int          idx;
		logic [4:0]  bk;
		int          eDone;
		int          eRej;
	} rrc_row_s;

	rrc_row_s rows [9] = '{
		'{24'hF1_C000, 3, 1'b1, -1, 5'h00, 1, 0},
		'{24'hFD_2C00, 4, 1'b1, 0, 5'h12, 1, 0},
		'{24'hFE_6C00, 4, 1'b1, 1, 5'h16, 1, 0},
		'{24'hF9_5C00, 4, 1'b1, 2, 5'h15, 1, 0},
		'{24'hFA_8C00, 4, 1'b1, 3, 5'h18, 1, 0},
		'{24'hFA_C000, 3, 1'b1, 3, 5'h00, 1, 0},
		'{24'hFD_1C00, 4, 1'b1, 0, 5'h11, 1, 0},
		'{24'hF2_C000, 3, 1'b0, -1, 5'h00, 1, 0},
		'{24'hFD_C000, 3, 1'b0, -1, 5'h00, 0, 1}
	};

	initial begin
		repeat (5) @(posedge sys_clk);
		#1 resetn = 1'b1;
		check("lineIdle", {b3, b2, b1, b0}, RRC_LINES_IDLE);
		check("modeReset", modeRemote, 1'b0);
		check("backupReset", backupState, 20'h0_0000);
		foreach (rows[i]) begin
			runSeq(rows[i].words, rows[i].n, 1'b0, rows[i].eRem, rows[i].idx, rows[i].bk,
				rows[i].eDone, rows[i].eRej);
		end
		// Awkward cases; auto while already automatic is refused first
		runSeq(24'hF2_C000, 3, 1'b0, 1'b0, -1, 5'h00, 0, 1);
		runSeq(24'hF1_C000, 3, 1'b1, 1'b1, -1, 5'h00, 1, 0);
		runSeq(24'hC0_0000, 1, 1'b0, 1'b1, -1, 5'h00, 0, 0);
		runSeq(24'hF1_C000, 3, 1'b0, 1'b1, -1, 5'h00, 0, 1);
		runSeq(24'hFC_0000, 2, 1'b0, 1'b1, -1, 5'h00, 0, 1);
		runSeq(24'hFD_9C00, 4, 1'b0, 1'b1, -1, 5'h00, 0, 1);
		runSeq(24'hFD_FE3C, 6, 1'b0, 1'b1, 1, 5'h13, 1, 0);
		// Stall past the gap limit after a start word
		runSeq(24'hF0_0000, 1, 1'b0, 1'b1, -1, 5'h00, 0, 0);
		gr = nRej;
		repeat (600) @(posedge sys_clk);
		check("gapReject", nRej - gr, 1);
		runSeq(24'hDC_0000, 2, 1'b0, 1'b1, -1, 5'h00, 0, 0);
		// Reset in mid-run drops remote mode and every online backup
		#1 resetn = 1'b0;
		repeat (2) @(posedge sys_clk);
		#1 resetn = 1'b1;
		check("modeMidReset", modeRemote, 1'b0);
		check("backupMidReset", backupState, 20'h0_0000);
		conclude();
	end
endmodule
`default_nettype wire
